/* File: core/arb_defs.svh */
// Constants for the processor request priority arbiter
`ifndef ARB_DEFS_SVH
`define ARB_DEFS_SVH

// ------------------------------------------------------------
// Widths and values
// ------------------------------------------------------------
`define DMA_COUNT_W 16
`define DMA_COUNT_ZERO 16'h0000
`define ACT_W 7

`endif

/* File: core/arb_pkg.sv */
// Types shared by the request priority arbiter
`include "arb_defs.svh"

package arb_pkg;

    // One-hot activity of the core
    typedef enum logic [`ACT_W-1:0] {
        ACT_NORMAL  = 7'h01,
        ACT_REFRESH = 7'h02,
        ACT_INTACK  = 7'h04,
        ACT_DMA     = 7'h08,
        ACT_BUSREL  = 7'h10,
        ACT_SLEEP   = 7'h20,
        ACT_SYSSTOP = 7'h40
    } act_t;

    // Requests sampled by the arbiter, all active high
    typedef struct packed {
        logic wait_request;
        logic wait_window;
        logic external_bus_request;
        logic refresh_request;
        logic dma_request_line;
        logic dma_edge_mode;
    } req_t;

    // Interrupt sources, all active high
    typedef struct packed {
        logic external_interrupt_zero;
        logic external_interrupt_one;
        logic external_interrupt_two;
        logic internal_interrupt;
        logic nmi;
        logic int_enable;
    } irq_t;

    // Decisions handed back to the core
    typedef struct packed {
        logic wait_insert;
        logic bus_release;
        logic refresh_start;
        logic dma_start;
        logic dma_terminate;
        logic irq_accept;
        logic nmi_accept;
        logic wake;
    } grant_t;

endpackage : arb_pkg

/* File: core/cpu_request_priority_arbiter.sv */
// Processor request priority arbiter: wait, per-cycle and per-instruction requests
// Functional notes
// - Wait honoured only while the bus sequencer opens its wait window.
// - Refresh and DMA granted at machine cycle boundaries; bus requests too, except in sleep and system stop.
// - Interrupts taken only at instruction boundaries.
// - Wait beats per-cycle requests, which beat interrupts.
// - Per-cycle order: bus request, then refresh, then DMA.
// - Bus request with simultaneous refresh request discards the refresh.
// - During refresh or bus release, level DMA refused, edge DMA kept.
// - DMA terminates once the byte count reaches zero.
`timescale 1ns/1ps
`include "arb_defs.svh"

module cpu_request_priority_arbiter (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic mc_end_i,
    input wire logic instr_end_i,
    input wire logic sleep_enter_i,
    input wire logic peripheral_halt_mode_i,
    input wire logic [`DMA_COUNT_W-1:0] dma_byte_count_i,
    input wire arb_pkg::req_t req_i,
    input wire arb_pkg::irq_t irq_i,
    output arb_pkg::grant_t grant_o,
    output arb_pkg::act_t activity_o
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic ext_maskable(input arb_pkg::irq_t irq);
        ext_maskable = irq.int_enable && (irq.external_interrupt_zero
            || irq.external_interrupt_one || irq.external_interrupt_two);
    endfunction : ext_maskable

    function automatic logic any_maskable(input arb_pkg::irq_t irq);
        any_maskable = ext_maskable(irq) || (irq.int_enable && irq.internal_interrupt);
    endfunction : any_maskable

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    arb_pkg::act_t act_reg;
    arb_pkg::act_t act_next;
    logic refresh_pend_reg;
    logic refresh_pend_next;
    logic nmi_pend_reg;
    logic nmi_pend_next;
    logic nmi_prev_reg;
    logic nmi_prev_next;
    arb_pkg::grant_t grant_reg;
    arb_pkg::grant_t grant_next;
    logic dma_pending;
    logic dma_blocked;
    logic dma_taken;
    logic wait_ok;
    logic wait_now;
    logic boundary;
    logic count_zero;
    logic nmi_rise;

    assign dma_blocked = (act_reg == arb_pkg::ACT_REFRESH) || (act_reg == arb_pkg::ACT_BUSREL);
    assign count_zero = (dma_byte_count_i == `DMA_COUNT_ZERO);
    assign nmi_rise = irq_i.nmi && !nmi_prev_reg;

    dma_request_capture u_dma_capture (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .line_i(req_i.dma_request_line),
        .edge_mode_i(req_i.dma_edge_mode),
        .blocked_i(dma_blocked),
        .taken_i(dma_taken),
        .pending_o(dma_pending)
    );

    // wait window only
    // Refresh, bus release and low power states never stretch
    assign wait_ok = (act_reg == arb_pkg::ACT_NORMAL) || (act_reg == arb_pkg::ACT_INTACK)
        || (act_reg == arb_pkg::ACT_DMA);
    assign wait_now = req_i.wait_request && req_i.wait_window && wait_ok;

    // wait holds off boundary
    // A stretched cycle has not ended, so no per-cycle or per-instruction grant yet
    assign boundary = mc_end_i && !wait_now;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        act_next = act_reg;
        refresh_pend_next = refresh_pend_reg;
        nmi_pend_next = nmi_pend_reg;
        nmi_prev_next = irq_i.nmi;
        grant_next = '0;
        dma_taken = 1'b0;
        grant_next.wait_insert = wait_now;
        if (nmi_rise) begin
            nmi_pend_next = 1'b1;
        end
        unique case (act_reg)
            arb_pkg::ACT_NORMAL,
            arb_pkg::ACT_INTACK,
            arb_pkg::ACT_DMA: begin
                if (boundary) begin
                    if (req_i.external_bus_request) begin
                        act_next = arb_pkg::ACT_BUSREL;
                        refresh_pend_next = 1'b0;
                    end else if (refresh_pend_reg) begin
                        act_next = arb_pkg::ACT_REFRESH;
                        refresh_pend_next = 1'b0;
                        grant_next.refresh_start = 1'b1;
                    end else if (act_reg == arb_pkg::ACT_DMA) begin
                        if (count_zero || nmi_pend_reg || !dma_pending) begin
                            act_next = arb_pkg::ACT_NORMAL;
                            grant_next.dma_terminate = 1'b1;
                        end
                    end else if (dma_pending) begin
                        act_next = arb_pkg::ACT_DMA;
                        dma_taken = 1'b1;
                        grant_next.dma_start = 1'b1;
                    end else if (act_reg == arb_pkg::ACT_INTACK) begin
                        act_next = arb_pkg::ACT_NORMAL;
                    end
                end
                // zero count ends transfer
                // A bus or refresh grant at that boundary must not swallow the terminate pulse
                if (act_reg == arb_pkg::ACT_DMA && boundary && count_zero) begin
                    grant_next.dma_terminate = 1'b1;
                end
                // interrupts at instruction end
                // Lowest rank: only when no per-cycle grant is made in this cycle
                if (act_reg == arb_pkg::ACT_NORMAL && instr_end_i && !wait_now
                        && act_next == arb_pkg::ACT_NORMAL) begin
                    if (nmi_pend_reg || nmi_rise) begin
                        act_next = arb_pkg::ACT_INTACK;
                        nmi_pend_next = 1'b0;
                        grant_next.nmi_accept = 1'b1;
                    end else if (any_maskable(irq_i)) begin
                        act_next = arb_pkg::ACT_INTACK;
                        grant_next.irq_accept = 1'b1;
                    end else if (sleep_enter_i) begin
                        act_next = peripheral_halt_mode_i ? arb_pkg::ACT_SYSSTOP
                            : arb_pkg::ACT_SLEEP;
                    end
                end
            end
            arb_pkg::ACT_REFRESH: begin
                // DMA after refresh
                // Refresh lasts one machine cycle; a kept DMA request follows it
                if (boundary) begin
                    act_next = arb_pkg::ACT_NORMAL;
                end
            end
            arb_pkg::ACT_BUSREL: begin
                if (!req_i.external_bus_request && mc_end_i) begin
                    act_next = arb_pkg::ACT_NORMAL;
                end
            end
            arb_pkg::ACT_SLEEP: begin
                if (nmi_pend_reg || nmi_rise || any_maskable(irq_i)) begin
                    act_next = arb_pkg::ACT_NORMAL;
                    grant_next.wake = 1'b1;
                end
            end
            arb_pkg::ACT_SYSSTOP: begin
                // stop wake sources
                // Peripherals are halted here, so their interrupts cannot wake the core
                if (nmi_pend_reg || nmi_rise || ext_maskable(irq_i)) begin
                    act_next = arb_pkg::ACT_NORMAL;
                    grant_next.wake = 1'b1;
                end
            end
            default: begin
                act_next = arb_pkg::ACT_NORMAL;
            end
        endcase
        // Set wins over a refresh grant that clears the flag in the same cycle
        if (req_i.refresh_request) begin
            refresh_pend_next = 1'b1;
        end
        if (req_i.refresh_request && boundary && req_i.external_bus_request
                && act_reg != arb_pkg::ACT_REFRESH && act_reg != arb_pkg::ACT_BUSREL) begin
            refresh_pend_next = 1'b0;
        end
        // Low power states have no refresh; a request there is dropped
        if (act_reg == arb_pkg::ACT_SLEEP || act_reg == arb_pkg::ACT_SYSSTOP) begin
            refresh_pend_next = 1'b0;
        end
        grant_next.bus_release = (act_next == arb_pkg::ACT_BUSREL)
            || ((act_reg == arb_pkg::ACT_SLEEP || act_reg == arb_pkg::ACT_SYSSTOP)
            && req_i.external_bus_request);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            act_reg <= arb_pkg::ACT_NORMAL;
            refresh_pend_reg <= 1'b0;
            nmi_pend_reg <= 1'b0;
            nmi_prev_reg <= 1'b0;
            grant_reg <= '0;
        end else begin
            act_reg <= act_next;
            refresh_pend_reg <= refresh_pend_next;
            nmi_pend_reg <= nmi_pend_next;
            nmi_prev_reg <= nmi_prev_next;
            grant_reg <= grant_next;
        end
    end

    assign grant_o = grant_reg;
    assign activity_o = act_reg;

endmodule : cpu_request_priority_arbiter

/* File: core/dma_request_capture.sv */
// DMA request capture for level and edge sense
`timescale 1ns/1ps

module dma_request_capture (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic line_i,
    input wire logic edge_mode_i,
    input wire logic blocked_i,
    input wire logic taken_i,
    output logic pending_o
);

    logic line_reg;
    logic line_next;
    logic edge_reg;
    logic edge_next;

    always_comb begin
        line_next = line_i;
        edge_next = edge_reg;
        if (taken_i) begin
            edge_next = 1'b0;
        end
        // Set wins over the clear taken in the same cycle
        if (line_i && !line_reg) begin
            edge_next = 1'b1;
        end
        if (!edge_mode_i) begin
            edge_next = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            line_reg <= 1'b0;
            edge_reg <= 1'b0;
        end else begin
            line_reg <= line_next;
            edge_reg <= edge_next;
        end
    end

    // level refused, edge kept
    // Level requests are simply not seen while blocked; edge requests stay latched
    assign pending_o = edge_mode_i ? (edge_reg && !blocked_i) : (line_i && !blocked_i);

endmodule : dma_request_capture

/* File: testbench/arb_chk.sv */
// Assertion checker bound to the request priority arbiter
`timescale 1ns/1ps
`include "arb_defs.svh"
module arb_chk (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic mc_end_i,
    input wire logic instr_end_i,
    input wire logic sleep_enter_i,
    input wire logic peripheral_halt_mode_i,
    input wire logic [`DMA_COUNT_W-1:0] dma_byte_count_i,
    input wire arb_pkg::req_t req_i,
    input wire arb_pkg::irq_t irq_i,
    input wire arb_pkg::grant_t grant_o,
    input wire arb_pkg::act_t activity_o
);
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    sequence s_busgo;
        mc_end_i && req_i.external_bus_request && !req_i.wait_request
            && activity_o == arb_pkg::ACT_NORMAL;
    endsequence
    property p_wait;
        grant_o.wait_insert |-> $past(req_i.wait_request && req_i.wait_window);
    endproperty
    a_wait: assert property (p_wait) else $error("wait outside window");
    property p_mc;
        grant_o.refresh_start || grant_o.dma_start |-> $past(mc_end_i);
    endproperty
    a_mc: assert property (p_mc) else $error("grant off boundary");
    property p_int;
        grant_o.irq_accept |-> $past(instr_end_i && activity_o == arb_pkg::ACT_NORMAL);
    endproperty
    a_int: assert property (p_int) else $error("interrupt off boundary");
    property p_nmi;
        grant_o.nmi_accept |-> $past(instr_end_i && activity_o == arb_pkg::ACT_NORMAL);
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi off boundary");
    property p_prio;
        mc_end_i && req_i.wait_request && req_i.wait_window
            && activity_o == arb_pkg::ACT_NORMAL |=> !grant_o.refresh_start && !grant_o.dma_start;
    endproperty
    a_prio: assert property (p_prio) else $error("grant during wait");
    property p_bus;
        s_busgo |=> activity_o == arb_pkg::ACT_BUSREL && grant_o.bus_release
            && !grant_o.refresh_start;
    endproperty
    a_bus: assert property (p_bus) else $error("bus request lost");
    property p_dma;
        activity_o inside {arb_pkg::ACT_REFRESH, arb_pkg::ACT_BUSREL} |=> !grant_o.dma_start;
    endproperty
    a_dma: assert property (p_dma) else $error("dma in refresh or release");
    property p_term;
        activity_o == arb_pkg::ACT_DMA && mc_end_i && dma_byte_count_i == `DMA_COUNT_ZERO
            && !req_i.wait_request && !req_i.external_bus_request |=> grant_o.dma_terminate;
    endproperty
    a_term: assert property (p_term) else $error("dma not ended");
    property p_stop;
        activity_o == arb_pkg::ACT_SYSSTOP && !irq_i.nmi && !irq_i.external_interrupt_zero
            && !irq_i.external_interrupt_one && !irq_i.external_interrupt_two |=> !grant_o.wake;
    endproperty
    a_stop: assert property (p_stop) else $error("bad wake");
endmodule : arb_chk
bind cpu_request_priority_arbiter arb_chk u_chk (.core_clk_i, .sys_rst_i, .mc_end_i,
    .instr_end_i, .sleep_enter_i, .peripheral_halt_mode_i, .dma_byte_count_i, .req_i, .irq_i,
    .grant_o, .activity_o);

/* File: testbench/bus_master_model.sv */
// External bus master that holds the bus a few release cycles
`timescale 1ns/1ps
module bus_master_model #(
    parameter int HOLD = 3
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic start_i,
    input wire logic bus_release_i,
    output logic external_bus_request_o
);
    logic [3:0] held_reg;
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || start_i) begin
            external_bus_request_o <= start_i;
            held_reg <= 4'h0;
        end else if (external_bus_request_o && bus_release_i) begin
            held_reg <= held_reg + 4'h1;
            if (held_reg == HOLD[3:0]) external_bus_request_o <= 1'b0;
        end
    end
endmodule : bus_master_model

/* File: testbench/tb_cpu_request_priority_arbiter.sv */
// Self-checking testbench for the request priority arbiter
`timescale 1ns/1ps
`include "arb_defs.svh"
module tb_cpu_request_priority_arbiter;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic mc = 1'b0;
    logic ie = 1'b0;
    logic slp = 1'b0;
    logic halt = 1'b0;
    logic [`DMA_COUNT_W-1:0] cnt = 16'h0005;
    logic bm_go = 1'b0;
    logic bm_req;
    arb_pkg::req_t rq = '0;
    arb_pkg::req_t rq_d;
    arb_pkg::irq_t iq = '0;
    arb_pkg::grant_t g;
    arb_pkg::act_t act;
    int bad_count = 0;
    int n_compared = 0;
    always_comb begin
        rq_d = rq;
        rq_d.external_bus_request = bm_req;
    end
    initial begin
        forever #2.5 clk = ~clk;
    end
    cpu_request_priority_arbiter dut (.core_clk_i(clk), .sys_rst_i(rst), .mc_end_i(mc),
        .instr_end_i(ie), .sleep_enter_i(slp), .peripheral_halt_mode_i(halt),
        .dma_byte_count_i(cnt), .req_i(rq_d), .irq_i(iq), .grant_o(g), .activity_o(act));
    bus_master_model bm (.core_clk_i(clk), .sys_rst_i(rst), .start_i(bm_go),
        .bus_release_i(g.bus_release), .external_bus_request_o(bm_req));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    // Inputs set at the falling edge stand for the next rising edge
    task automatic step(input logic m, input logic i);
        mc = m;
        ie = i;
        @(negedge clk);
    endtask : step
    task automatic wait_normal();
        int k;
        for (k = 0; k < 20 && act !== arb_pkg::ACT_NORMAL; k++) step(1'b1, 1'b0);
        if (act !== arb_pkg::ACT_NORMAL) begin
            bad_count++;
            finish_test();
        end
    endtask : wait_normal
    task automatic t_refresh();
        rq.refresh_request = 1'b1;
        step(1'b0, 1'b0);
        rq.refresh_request = 1'b0;
        rq.wait_request = 1'b1;
        step(1'b0, 1'b0);
        chk(g.wait_insert, 1'b0);
        rq.wait_window = 1'b1;
        step(1'b1, 1'b0);
        chk(g.wait_insert, 1'b1);
        chk(g.refresh_start, 1'b0);
        rq.wait_request = 1'b0;
        rq.wait_window = 1'b0;
        step(1'b1, 1'b0);
        chk(g.refresh_start, 1'b1);
        chk(act, arb_pkg::ACT_REFRESH);
        // A wait inside a refresh cycle must not stretch it
        rq.wait_request = 1'b1;
        rq.wait_window = 1'b1;
        step(1'b1, 1'b0);
        chk(g.wait_insert, 1'b0);
        chk(act, arb_pkg::ACT_NORMAL);
        rq.wait_request = 1'b0;
        rq.wait_window = 1'b0;
        wait_normal();
        $display("refresh test done");
    endtask : t_refresh
    task automatic t_bus();
        rq.dma_request_line = 1'b1;
        bm_go = 1'b1;
        step(1'b0, 1'b0);
        bm_go = 1'b0;
        // Refresh raised on the very boundary that grants the bus
        rq.refresh_request = 1'b1;
        step(1'b1, 1'b0);
        rq.refresh_request = 1'b0;
        chk(act, arb_pkg::ACT_BUSREL);
        chk(g.refresh_start, 1'b0);
        step(1'b1, 1'b0);
        chk(g.dma_start, 1'b0);
        wait_normal();
        step(1'b1, 1'b0);
        chk(g.refresh_start, 1'b0);
        chk(g.dma_start, 1'b1);
        cnt = 16'h0000;
        step(1'b1, 1'b0);
        chk(g.dma_terminate, 1'b1);
        rq.dma_request_line = 1'b0;
        cnt = 16'h0005;
        wait_normal();
        $display("bus and dma test done");
    endtask : t_bus
    // Same short request during bus release: level sense loses it, edge sense keeps it
    task automatic t_edge();
        for (int m = 0; m < 2; m++) begin
            bm_go = 1'b1;
            rq.dma_edge_mode = m[0];
            step(1'b0, 1'b0);
            bm_go = 1'b0;
            step(1'b1, 1'b0);
            rq.dma_request_line = 1'b1;
            step(1'b0, 1'b0);
            rq.dma_request_line = 1'b0;
            wait_normal();
            step(1'b1, 1'b0);
            chk(g.dma_start, m[0]);
            wait_normal();
        end
        rq.dma_edge_mode = 1'b0;
        $display("edge dma test done");
    endtask : t_edge
    task automatic t_irq();
        iq.int_enable = 1'b1;
        iq.external_interrupt_one = 1'b1;
        step(1'b1, 1'b0);
        chk(g.irq_accept, 1'b0);
        rq.wait_request = 1'b1;
        rq.wait_window = 1'b1;
        step(1'b1, 1'b1);
        chk(g.irq_accept, 1'b0);
        chk(g.wait_insert, 1'b1);
        rq.wait_request = 1'b0;
        rq.wait_window = 1'b0;
        step(1'b0, 1'b1);
        chk(g.irq_accept, 1'b1);
        iq.external_interrupt_one = 1'b0;
        wait_normal();
        halt = 1'b1;
        slp = 1'b1;
        step(1'b0, 1'b1);
        slp = 1'b0;
        chk(act, arb_pkg::ACT_SYSSTOP);
        iq.internal_interrupt = 1'b1;
        step(1'b0, 1'b0);
        chk(g.wake, 1'b0);
        iq.internal_interrupt = 1'b0;
        iq.external_interrupt_zero = 1'b1;
        step(1'b0, 1'b0);
        chk(g.wake, 1'b1);
        chk(act, arb_pkg::ACT_NORMAL);
        iq.external_interrupt_zero = 1'b0;
        halt = 1'b0;
        slp = 1'b1;
        step(1'b0, 1'b1);
        slp = 1'b0;
        chk(act, arb_pkg::ACT_SLEEP);
        iq.internal_interrupt = 1'b1;
        step(1'b0, 1'b0);
        chk(g.wake, 1'b1);
        chk(act, arb_pkg::ACT_NORMAL);
        iq.internal_interrupt = 1'b0;
        $display("interrupt and wake test done");
    endtask : t_irq
    task automatic t_nmi();
        rq.dma_request_line = 1'b1;
        step(1'b1, 1'b0);
        chk(g.dma_start, 1'b1);
        iq.nmi = 1'b1;
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        chk(g.dma_terminate, 1'b1);
        rq.dma_request_line = 1'b0;
        step(1'b0, 1'b1);
        chk(g.nmi_accept, 1'b1);
        iq.nmi = 1'b0;
        wait_normal();
        slp = 1'b1;
        step(1'b0, 1'b1);
        slp = 1'b0;
        chk(act, arb_pkg::ACT_SLEEP);
        iq.nmi = 1'b1;
        step(1'b0, 1'b0);
        chk(g.wake, 1'b1);
        step(1'b0, 1'b1);
        chk(g.nmi_accept, 1'b1);
        iq.nmi = 1'b0;
        wait_normal();
        $display("nmi test done");
    endtask : t_nmi
    initial begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        step(1'b0, 1'b0);
        t_refresh();
        t_bus();
        t_edge();
        t_irq();
        t_nmi();
        step(1'b0, 1'b0);
        finish_test();
    end
endmodule : tb_cpu_request_priority_arbiter
